// ### rtl/pd_tx_pkg.sv
// Constants, types and encoders shared by the transmit queue framer.
package pd_tx_pkg;
  // ==========================================================
  // Queue window
  localparam logic [15:0] QUEUE_BASE  = 16'h1800;
  localparam logic [15:0] QUEUE_TOP   = 16'h1849;
  localparam logic [6:0]  QUEUE_DEPTH = 7'h4A;
  localparam logic [7:0]  QUEUE_RST   = 8'h00;
  // ==========================================================
  // Raw control bytes and K-codes
  localparam logic [7:0] CODE_INS_CRC = 8'hFF;
  localparam logic [7:0] CODE_STOP    = 8'hFE;
  localparam logic [4:0] K_SYNC1      = 5'h18;
  localparam logic [4:0] K_SYNC2      = 5'h11;
  localparam logic [4:0] K_SYNC3      = 5'h06;
  localparam logic [4:0] K_EOP        = 5'h0D;
  // ==========================================================
  // Symbol buffer and CRC
  localparam int          SYM_W      = 5;
  localparam int          SYM_DEPTH  = 8;
  localparam logic [31:0] CRC_INIT   = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY   = 32'hEDB88320;
  // ==========================================================
  // Auto-response messages
  localparam logic [3:0] MSG_GOODCRC    = 4'h1;
  localparam logic [3:0] MSG_BIST       = 4'h3;
  localparam logic [3:0] BIST_ERR_COUNT = 4'h5;
  localparam logic [6:0] LEN_GOODCRC    = 7'h02;
  localparam logic [6:0] LEN_BIST       = 7'h06;
  localparam logic [2:0] RETRY_RST      = 3'h0;
  localparam logic [8:0] PRE_RST        = 9'h000;
  localparam logic [7:0] TICK_RST       = 8'h00;

  typedef enum logic [2:0] {
    GEN_IDLE, GEN_SOP, GEN_BODY, GEN_CRC, GEN_EOP, GEN_TAIL, GEN_WAIT
  } gen_state_t;

  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    case (n)
      4'h0: enc4b5b = 5'h1E;  4'h1: enc4b5b = 5'h09;
      4'h2: enc4b5b = 5'h14;  4'h3: enc4b5b = 5'h15;
      4'h4: enc4b5b = 5'h0A;  4'h5: enc4b5b = 5'h0B;
      4'h6: enc4b5b = 5'h0E;  4'h7: enc4b5b = 5'h0F;
      4'h8: enc4b5b = 5'h12;  4'h9: enc4b5b = 5'h13;
      4'hA: enc4b5b = 5'h16;  4'hB: enc4b5b = 5'h17;
      4'hC: enc4b5b = 5'h1A;  4'hD: enc4b5b = 5'h1B;
      4'hE: enc4b5b = 5'h1C;  default: enc4b5b = 5'h1D;
    endcase
  endfunction

  function automatic logic [31:0] crcNib(input logic [31:0] c,
                                         input logic [3:0] n);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      r = (r[0] ^ n[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crcNib = r;
  endfunction
endpackage

// ### rtl/pd_mac_tx_queue_framer.sv
// Transmit queue, framer, CRC, 4b5b encoder and serializer.

module sym_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem[rdPtr_ff];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wrPtr_ff <= wrPtr_ff + 1'b1;
      if (pop) rdPtr_ff <= rdPtr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module pd_mac_tx_queue_framer (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  // Queue window access
  input  wire logic [15:0]           regAddr,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [7:0]            regWrData,
  output logic      [7:0]            regRdData,
  // Control fields
  input  wire logic                  queueFifoSelect,
  input  wire logic                  rawProcessingSelect,
  input  wire logic [6:0]            messageLengthValue,
  input  wire logic                  clearQueueWritePointer,
  input  wire logic                  goSet,
  input  wire logic [2:0]            retryCount,
  input  wire logic [1:0]            sopSelect,
  input  wire logic [7:0]            bitTime,
  input  wire logic [8:0]            preambleLength,
  // Status
  output logic                       goBusy,
  output logic                       transmitPermitted,
  output logic                       txDone,
  output logic                       txFailed,
  // Auto response and acknowledge events
  input  wire logic                  ackRequest,
  input  wire logic                  bistRequest,
  input  wire logic [15:0]           bistErrorCount,
  input  wire logic [2:0]            headerMessageId,
  input  wire logic                  headerPowerRole,
  input  wire logic                  headerDataRole,
  input  wire logic [1:0]            headerSpecRev,
  input  wire logic                  ackReceived,
  input  wire logic                  ackTimeout,
  // Serial bits to the BMC encoder
  output logic                       txBit,
  output logic                       txActive
);
  import pd_tx_pkg::*;

  logic [7:0]  queue [QUEUE_DEPTH];
  logic [7:0]  regRdData_ff;
  logic [6:0]  wrPtr_ff;
  logic        goBusy_ff, permit_ff, txDone_ff, txFailed_ff;
  logic        autoPend_ff;
  logic [47:0] autoMsg_ff;
  logic [6:0]  autoLen_ff;
  gen_state_t  state_ff;
  logic [6:0]  rdIdx_ff, lenRun_ff;
  logic        nibHi_ff, srcAuto_ff, rawRun_ff;
  logic [2:0]  kIdx_ff, retriesLeft_ff;
  logic [31:0] crc_ff;
  logic        txBit_ff, txActive_ff;
  logic [8:0]  preLeft_ff;
  logic [2:0]  bitsLeft_ff;
  logic [3:0]  shreg_ff;
  logic [7:0]  tick_ff;
  logic        qHit, startNow, nxtRaw, fire, avail, idleDone;
  logic        pushVal, useCrc, inRdy, outVal, popSym, bitTick;
  logic        finishSw;
  logic [4:0]  sym, outSym;
  logic [3:0]  nib;
  logic [7:0]  curByte;
  logic [6:0]  qOff;
  logic [15:0] hdr;
  logic [31:0] crcOut;

  assign regRdData         = regRdData_ff;
  assign goBusy            = goBusy_ff;
  assign transmitPermitted = permit_ff;
  assign txDone            = txDone_ff;
  assign txFailed          = txFailed_ff;
  assign txBit             = txBit_ff;
  assign txActive          = txActive_ff;

  // ==========================================================
  // Queue window
  assign qHit = (regAddr >= QUEUE_BASE) && (regAddr <= QUEUE_TOP);
  assign qOff = regAddr[6:0];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < QUEUE_DEPTH; i++) queue[i] <= QUEUE_RST;
    end else if (regWrite && qHit) begin
      if (!queueFifoSelect) begin
        queue[qOff] <= regWrData;
      end else if (wrPtr_ff < QUEUE_DEPTH && !clearQueueWritePointer) begin
        queue[wrPtr_ff] <= regWrData;
      end
    end
  end

  // pointer clear wins over a write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_ff <= '0;
    end else if (clearQueueWritePointer) begin
      wrPtr_ff <= '0;
    end else if (regWrite && qHit && queueFifoSelect && wrPtr_ff < QUEUE_DEPTH) begin
      wrPtr_ff <= wrPtr_ff + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_ff <= 8'h00;
    end else if (regRead && qHit && !queueFifoSelect) begin
      regRdData_ff <= queue[qOff];
    end else begin
      regRdData_ff <= 8'h00;
    end
  end

  // ==========================================================
  // Requests: go and automatic responses
  assign hdr = {1'b0, (bistRequest ? 3'h1 : 3'h0), headerMessageId,
                headerPowerRole, headerSpecRev, headerDataRole, 1'b0,
                (bistRequest ? MSG_BIST : MSG_GOODCRC)};
  assign finishSw   = (state_ff == GEN_WAIT) &&
                      (ackReceived || (ackTimeout && retriesLeft_ff == '0));

  // capture a response; a new request beats the clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      autoPend_ff <= 1'b0;
      autoMsg_ff  <= '0;
      autoLen_ff  <= '0;
    end else if (ackRequest || bistRequest) begin
      autoPend_ff <= 1'b1;
      autoMsg_ff  <= {BIST_ERR_COUNT, 12'h000, bistErrorCount, hdr};
      autoLen_ff  <= bistRequest ? LEN_BIST : LEN_GOODCRC;
    end else if (state_ff == GEN_IDLE && autoPend_ff) begin
      autoPend_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      goBusy_ff   <= 1'b0;
      permit_ff   <= 1'b0;
      txDone_ff   <= 1'b0;
      txFailed_ff <= 1'b0;
    end else begin
      if (goSet) goBusy_ff <= 1'b1;
      else if (finishSw) goBusy_ff <= 1'b0;
      permit_ff   <= !goBusy_ff && !goSet && (state_ff == GEN_IDLE);
      txDone_ff   <= finishSw && ackReceived;
      txFailed_ff <= finishSw && !ackReceived;
    end
  end

  // ==========================================================
  // Symbol generator
  assign curByte = srcAuto_ff ? autoMsg_ff[{rdIdx_ff[2:0], 3'b000} +: 8]
                 : (rdIdx_ff < QUEUE_DEPTH) ? queue[rdIdx_ff] : 8'h00;
  // in FIFO mode, never read past the write pointer; buffer reads are not limited by it
  assign avail    = srcAuto_ff || !queueFifoSelect || (rdIdx_ff < wrPtr_ff);
  assign crcOut   = ~crc_ff;
  assign idleDone = !txActive_ff && !outVal;
  assign nxtRaw   = (state_ff == GEN_IDLE) ? (!autoPend_ff && rawProcessingSelect)
                  : rawRun_ff;
  assign startNow = ((state_ff == GEN_IDLE) && (autoPend_ff || goBusy_ff)) ||
                    ((state_ff == GEN_WAIT) && ackTimeout && !ackReceived &&
                     retriesLeft_ff != '0);
  assign fire     = pushVal && inRdy;

  always_comb begin
    pushVal = 1'b0;
    useCrc  = 1'b0;
    nib     = nibHi_ff ? curByte[7:4] : curByte[3:0];
    sym     = enc4b5b(nib);
    case (state_ff)
      GEN_SOP: begin
        pushVal = 1'b1;
        case (sopSelect)
          2'h1:    sym = (kIdx_ff < 3'h2) ? K_SYNC1 : K_SYNC3;
          2'h2:    sym = kIdx_ff[0] ? K_SYNC3 : K_SYNC1;
          default: sym = (kIdx_ff == 3'h3) ? K_SYNC2 : K_SYNC1;
        endcase
      end
      GEN_BODY: begin
        if (rawRun_ff) begin
          nib = curByte[3:0];
          if (curByte != CODE_INS_CRC && curByte != CODE_STOP && avail) begin
            pushVal = 1'b1;
            if (curByte[5]) sym = curByte[4:0];
            else begin
              sym    = enc4b5b(nib);
              useCrc = 1'b1;
            end
          end
        end else begin
          pushVal = avail;
          useCrc  = avail;
        end
      end
      GEN_CRC: begin
        pushVal = 1'b1;
        sym     = enc4b5b(crcOut[{kIdx_ff, 2'b00} +: 4]);
      end
      GEN_EOP: begin
        pushVal = 1'b1;
        sym     = K_EOP;
      end
      default: pushVal = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) crc_ff <= CRC_INIT;
    else if (startNow) crc_ff <= CRC_INIT;
    else if (fire && useCrc) crc_ff <= crcNib(crc_ff, nib);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      srcAuto_ff <= 1'b0;
      rawRun_ff  <= 1'b0;
      lenRun_ff  <= '0;
    end else if (state_ff == GEN_IDLE) begin
      srcAuto_ff <= autoPend_ff;
      rawRun_ff  <= nxtRaw;
      lenRun_ff  <= autoPend_ff ? autoLen_ff : messageLengthValue;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) retriesLeft_ff <= RETRY_RST;
    else if (state_ff == GEN_IDLE) retriesLeft_ff <= retryCount;
    else if (startNow) retriesLeft_ff <= retriesLeft_ff - 3'h1;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= GEN_IDLE;
      rdIdx_ff <= '0;
      nibHi_ff <= 1'b0;
      kIdx_ff  <= '0;
    end else if (startNow) begin
      state_ff <= nxtRaw ? GEN_BODY : GEN_SOP;
      rdIdx_ff <= '0;
      nibHi_ff <= 1'b0;
      kIdx_ff  <= '0;
    end else begin
      case (state_ff)
        GEN_SOP: if (fire) begin
          kIdx_ff <= kIdx_ff + 3'h1;
          if (kIdx_ff == 3'h3) begin
            kIdx_ff  <= '0;
            state_ff <= (lenRun_ff == '0) ? GEN_CRC : GEN_BODY;
          end
        end
        GEN_BODY: if (rawRun_ff) begin
          // raw ends on the stop code, or when a FIFO read reaches the write pointer
          if (curByte == CODE_STOP || !avail) state_ff <= GEN_TAIL;
          else if (curByte == CODE_INS_CRC) state_ff <= GEN_CRC;
          if (curByte == CODE_INS_CRC || fire) begin
            // Only the buffer wraps; a FIFO read halts at the write pointer instead.
            if (!queueFifoSelect && rdIdx_ff + 7'h01 == QUEUE_DEPTH) rdIdx_ff <= 7'h00;
            else rdIdx_ff <= rdIdx_ff + 7'h01;
          end
        end else if (!avail) begin
          state_ff <= GEN_CRC;
        end else if (fire) begin
          nibHi_ff <= !nibHi_ff;
          if (nibHi_ff) begin
            rdIdx_ff <= rdIdx_ff + 7'h01;
            if (rdIdx_ff + 7'h01 == lenRun_ff) state_ff <= GEN_CRC;
          end
        end
        GEN_CRC: if (fire) begin
          kIdx_ff <= kIdx_ff + 3'h1;
          if (kIdx_ff == 3'h7) state_ff <= rawRun_ff ? GEN_BODY : GEN_EOP;
        end
        GEN_EOP: if (fire) state_ff <= GEN_TAIL;
        GEN_TAIL: if (idleDone) state_ff <= srcAuto_ff ? GEN_IDLE : GEN_WAIT;
        GEN_WAIT: if (finishSw) state_ff <= GEN_IDLE;
        default: state_ff <= GEN_IDLE;
      endcase
    end
  end

  sym_fifo #(.WIDTH(SYM_W), .DEPTH(SYM_DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .inValid  (pushVal),
    .inReady  (inRdy),
    .inData   (sym),
    .outValid (outVal),
    .outReady (popSym),
    .outData  (outSym)
  );

  // ==========================================================
  // Serializer with preamble
  assign bitTick = (tick_ff == '0);
  assign popSym  = bitTick && txActive_ff && preLeft_ff == '0 && bitsLeft_ff == '0;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) tick_ff <= TICK_RST;
    else if (bitTick) tick_ff <= bitTime;
    else tick_ff <= tick_ff - 8'h01;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txBit_ff    <= 1'b0;
      txActive_ff <= 1'b0;
      preLeft_ff  <= PRE_RST;
      bitsLeft_ff <= '0;
      shreg_ff    <= '0;
    end else if (bitTick) begin
      if (!txActive_ff) begin
        txActive_ff <= outVal;
        preLeft_ff  <= outVal ? preambleLength : PRE_RST;
      end else if (preLeft_ff != '0) begin
        txBit_ff   <= preLeft_ff[0];
        preLeft_ff <= preLeft_ff - 9'h001;
      end else if (bitsLeft_ff != '0) begin
        txBit_ff    <= shreg_ff[0];
        shreg_ff    <= {1'b0, shreg_ff[3:1]};
        bitsLeft_ff <= bitsLeft_ff - 3'h1;
      end else if (outVal) begin
        txBit_ff    <= outSym[0];
        shreg_ff    <= outSym[4:1];
        bitsLeft_ff <= 3'h4;
      end else if (state_ff != GEN_BODY && state_ff != GEN_CRC) begin
        txActive_ff <= 1'b0;
        txBit_ff    <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  fifo_noread_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    regRead && qHit && queueFifoSelect |=> regRdData == 8'h00)
    else $error("queue read returned data in FIFO mode");
  buf_readback_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    regWrite && qHit && !queueFifoSelect ##1 regRead && !regWrite &&
    !queueFifoSelect && regAddr == $past(regAddr) |=> regRdData == $past(regWrData, 2))
    else $error("buffer readback mismatch");
  ptr_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clearQueueWritePointer |=> wrPtr_ff == 7'h00)
    else $error("write pointer not cleared");
  fifo_order_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    regWrite && qHit && queueFifoSelect && !clearQueueWritePointer &&
    wrPtr_ff < QUEUE_DEPTH |=> wrPtr_ff == $past(wrPtr_ff) + 7'h01)
    else $error("FIFO pointer did not advance");
  go_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    goBusy_ff && !finishSw |=> goBusy_ff)
    else $error("go dropped before completion");
  stop_code_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_ff == GEN_BODY && rawRun_ff && curByte == CODE_STOP && !startNow
    |=> state_ff == GEN_TAIL)
    else $error("stop code did not end packet");
  ins_crc_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_ff == GEN_BODY && rawRun_ff && curByte == CODE_INS_CRC && avail
    |=> state_ff == GEN_CRC && kIdx_ff == 3'h0)
    else $error("CRC insert code ignored");
  kcode_nocrc_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fire && state_ff == GEN_BODY && rawRun_ff && curByte[5] |=> $stable(crc_ff))
    else $error("K-code entered CRC");
endmodule

// ### sim/bmc_sink.sv
// Behavioural sink that stands where the BMC encoder takes the serial bits.
module bmc_sink (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Serial bits and bit period
  input  wire logic       txBit,
  input  wire logic       txActive,
  input  wire logic [7:0] bitTime
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bits [$];
  int   cnt;
  // ==========================================
  // Bit capture
  // one sample per bit
  // Sampling mid period keeps the capture clear of the design's bit-tick edges.
  // The first period of txActive carries no bit yet, so it is skipped.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
    end else if (txActive !== 1'b1) begin
      cnt <= 0;
    end else begin
      if (cnt > bitTime && cnt % (bitTime + 1) == (bitTime + 1) / 2) begin
        bits.push_back(txBit);
      end
      cnt <= cnt + 1;
    end
  end
endmodule

// ### sim/tb_top.sv
// Bench for the transmit queue framer with a queue-based model of each frame.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pd_tx_pkg::*;
  // ==========================================
  // Signals and model state
  logic        ref_clk = 0, arst_n = 0, regWrite = 0, regRead = 0, goSet = 0;
  logic        queueFifoSelect = 0, rawProcessingSelect = 0, clearQueueWritePointer = 0;
  logic        ackRequest = 0, bistRequest = 0, ackReceived = 0, ackTimeout = 0;
  logic        headerPowerRole = 0, headerDataRole = 0, stop;
  logic [15:0] regAddr = 16'h0000, bistErrorCount = 16'h0000;
  logic [7:0]  regWrData = 8'h00, regRdData, bitTime = 8'h03, rnd = 8'h5F;
  logic [6:0]  messageLengthValue = 7'h00;
  logic [8:0]  preambleLength = 9'h008;
  logic [2:0]  retryCount = 3'h0, headerMessageId = 3'h0;
  logic [1:0]  sopSelect = 2'h0, headerSpecRev = 2'h0;
  logic        goBusy, transmitPermitted, txDone, txFailed, txBit, txActive;
  logic [7:0]  mem [74];
  logic [7:0]  raw [13];
  logic [4:0]  enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic [4:0]  sopt [3][4] = '{'{K_SYNC1, K_SYNC1, K_SYNC1, K_SYNC2},
                               '{K_SYNC1, K_SYNC1, K_SYNC3, K_SYNC3},
                               '{K_SYNC1, K_SYNC3, K_SYNC1, K_SYNC3}};
  logic        e [$];
  logic [31:0] crc, crcWord;
  int          error_cnt = 0, tests_run = 0, cyc = 0, offs;

  pd_mac_tx_queue_framer i_dut (.ref_clk, .arst_n, .regAddr, .regWrite, .regRead,
    .regWrData, .regRdData, .queueFifoSelect, .rawProcessingSelect, .messageLengthValue,
    .clearQueueWritePointer, .goSet, .retryCount, .sopSelect, .bitTime, .preambleLength,
    .goBusy, .transmitPermitted, .txDone, .txFailed, .ackRequest, .bistRequest,
    .bistErrorCount, .headerMessageId, .headerPowerRole, .headerDataRole, .headerSpecRev,
    .ackReceived, .ackTimeout, .txBit, .txActive);
  bmc_sink i_sink (.ref_clk, .arst_n, .txBit, .txActive, .bitTime);

  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      conclude();
    end
  end
  // ==========================================
  // Tasks
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {regAddr, regWrData, regWrite} = {a, d, 1'b1};
    @(negedge ref_clk);
    regWrite = 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {regAddr, regRead} = {a, 1'b1};
    @(negedge ref_clk);
    regRead = 0;
    chk("regRdData", d, regRdData);
  endtask
  // Bit k of the word strobes one single-cycle request for exactly one cycle.
  task automatic pulse(input int k);
    @(negedge ref_clk);
    {clearQueueWritePointer, bistRequest, ackRequest, ackTimeout, ackReceived, goSet} = 6'(1 << k);
    @(negedge ref_clk);
    {clearQueueWritePointer, bistRequest, ackRequest, ackTimeout, ackReceived, goSet} = 6'h00;
  endtask
  task automatic sym(input logic [4:0] s);
    for (int i = 0; i < 5; i++) e.push_back(s[i]);
  endtask
  task automatic nib(input logic [3:0] n);
    for (int i = 0; i < 4; i++) crc = (crc[0] ^ n[i]) ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
    sym(enc[n]);
  endtask
  task automatic crcout();
    logic [31:0] c;
    c = ~crc;
    for (int i = 0; i < 8; i++) sym(enc[c[4*i+:4]]);
  endtask
  task automatic start();
    e.delete();
    i_sink.bits.delete();
    crc = CRC_INIT;
    for (int i = 0; i < preambleLength; i++) e.push_back(i[0]);
  endtask
  task automatic autoexp(input int s, input int n);
    start();
    for (int i = 0; i < 4; i++) sym(sopt[s][i]);
    for (int i = 0; i < n; i++) begin
      nib(mem[i][3:0]);
      nib(mem[i][7:4]);
    end
    crcout();
    sym(K_EOP);
  endtask
  task automatic go();
    chk("transmitPermitted", 1, transmitPermitted);
    pulse(0);
    chk("goBusy", 1, goBusy);
  endtask
  task automatic frame(input logic full);
    int bad;
    bad = -1;
    for (int t = 0; t < 3000 && txActive !== 1'b1; t++) @(negedge ref_clk);
    for (int t = 0; t < 9000 && txActive !== 1'b0; t++) @(negedge ref_clk);
    chk("frame bits", 32'(e.size()), 32'(i_sink.bits.size()));
    for (int i = 0; i < e.size() && full; i++) if (bad < 0 && i_sink.bits[i] !== e[i]) bad = i;
    chk("first wrong bit", -1, bad);
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic ack();
    pulse(1);
    for (int t = 0; t < 20 && txDone !== 1'b1; t++) @(negedge ref_clk);
    chk("txDone", 1, txDone);
    repeat (2) @(negedge ref_clk);
    chk("goBusy", 0, goBusy);
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1;
    for (int i = 73; i >= 0; i--) begin
      rnd = lfsr(rnd);
      mem[i] = rnd;
      wr(QUEUE_BASE + 16'(i), rnd);
    end
    // write then read back in the very next cycle
    rnd = lfsr(rnd);
    mem[16] = rnd;
    @(negedge ref_clk);
    {regAddr, regWrData, regWrite} = {QUEUE_BASE + 16'h0010, rnd, 1'b1};
    @(negedge ref_clk);
    {regWrite, regRead} = 2'b01;
    @(negedge ref_clk);
    regRead = 0;
    chk("regRdData", rnd, regRdData);
    for (int i = 0; i < 74; i++) rd(QUEUE_BASE + 16'(i), mem[i]);
    rd(16'h184A, 8'h00);
    for (int s = 0; s < 3; s++) begin
      sopSelect = 2'(s);
      messageLengthValue = 7'(2 + 2 * s);
      autoexp(s, 2 + 2 * s);
      go();
      frame(1);
      ack();
    end
    retryCount = 3'h1;
    sopSelect = 2'h0;
    messageLengthValue = 7'h02;
    autoexp(0, 2);
    go();
    frame(1);
    autoexp(0, 2);
    pulse(2);
    frame(1);
    pulse(2);
    for (int t = 0; t < 20 && txFailed !== 1'b1; t++) @(negedge ref_clk);
    chk("txFailed", 1, txFailed);
    rawProcessingSelect = 1;
    messageLengthValue = 7'h01;
    raw = '{8'h38, 8'h38, 8'h38, 8'h31, 8'h00, 8'h00, 8'h00, 8'h00, 8'h27, 8'hFF, 8'h2D, 8'hFE, 8'h05};
    // Pass 0 uses the FIFO and hardware CRC, pass 1 the buffer and a software CRC.
    for (int p = 0; p < 2; p++) begin
      queueFifoSelect = (p == 0);
      wr(QUEUE_BASE, 8'h2D);
      pulse(5);
      start();
      stop = 0;
      offs = 0;
      if (p == 1) raw[8] = 8'h20;
      for (int i = 0; i < 13; i++) begin
        if (i > 3 && i < 8) rnd = lfsr(rnd);
        if (i > 3 && i < 8) raw[i] = {4'h0, rnd[3:0]};
        if (p == 1 && raw[i] == CODE_INS_CRC) begin
          crcWord = ~crc;
          for (int j = 0; j < 8; j++) begin
            wr(QUEUE_BASE + 16'(offs), {4'h0, crcWord[4*j+:4]});
            offs++;
            nib(crcWord[4*j+:4]);
          end
        end else begin
          wr(QUEUE_BASE + 16'(p ? offs : (offs * 7) % 74), raw[i]);
          offs++;
          if (raw[i] == CODE_STOP) stop = 1;
          else if (stop) stop = 1;
          else if (raw[i] == CODE_INS_CRC) crcout();
          else if (raw[i][5]) sym(raw[i][4:0]);
          else nib(raw[i][3:0]);
        end
      end
      rd(QUEUE_BASE + 16'h0003, p ? raw[3] : 8'h00);
      go();
      frame(1);
      ack();
    end
    queueFifoSelect = 0;
    rawProcessingSelect = 0;
    for (int k = 3; k < 5; k++) begin
      rnd = lfsr(rnd);
      {headerMessageId, headerPowerRole, headerDataRole, headerSpecRev} = rnd[6:0];
      bistErrorCount = {rnd, ~rnd};
      // protocol header, then the error-count data object
      {mem[1], mem[0]} = {1'b0, 3'(k - 3), headerMessageId, headerPowerRole, headerSpecRev,
                          headerDataRole, 1'b0, (k == 3 ? MSG_GOODCRC : MSG_BIST)};
      {mem[5], mem[4], mem[3], mem[2]} = {BIST_ERR_COUNT, 12'h000, bistErrorCount};
      autoexp(0, 2 + 4 * (k - 3));
      pulse(k);
      frame(1);
    end
    conclude();
  end
endmodule
